/* File: design/dmd_pkg.sv */
// constants and types for the data memory and special register decoder
package dmd_pkg;
  // internal ram and expansion ram
  localparam int IRAM_DEPTH = 256;
  localparam int EXPANSION_RAM_DEPTH = 4096;
  localparam int EXPANSION_RAM_AW = 12;
  localparam logic [7:0] DIRECT_RAM_TOP = 8'h7F;
  localparam logic [3:0] BIT_BYTE_BASE_HI = 4'h2;
  // reset values
  localparam logic [7:0] STACK_POINTER_RST = 8'h07;
  localparam logic [7:0] PAGE_SELECT_RST = 8'h00;
  localparam logic [7:0] STATUS_WORD_RST = 8'h00;
  // program status word field
  localparam int BANK_SELECT_LOW_POS = 3;
  // common special registers, decoded on every page
  localparam logic [7:0] A_STACK_POINTER = 8'h81;
  localparam logic [7:0] A_DPTR_LOW = 8'h82;
  localparam logic [7:0] A_DPTR_HIGH = 8'h83;
  localparam logic [7:0] A_PAGE_SELECT = 8'hA7;
  localparam logic [7:0] A_STATUS_WORD = 8'hD0;
  localparam logic [7:0] A_ACCUM = 8'hE0;
  localparam logic [7:0] A_B_REG = 8'hF0;
  localparam logic [7:0] COMMON_PAGE = 8'h00;
  // access kinds issued by the core
  typedef enum logic [2:0] {
    K_DIRECT = 3'h0,
    K_INDIRECT = 3'h1,
    K_BIT = 3'h2,
    K_PUSH = 3'h3,
    K_POP = 3'h4,
    K_XMOVE = 3'h5,
    K_CODE = 3'h6
  } dmd_kind_t;
  // access sequencer, gray along idle-exec-writeback
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_EXEC = 2'h1,
    ST_WBAK = 2'h3
  } dmd_state_t;
  // ahb-lite register map
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam int CTRL_REDIRECT_POS = 0;
endpackage

/* File: design/dmd_sreg_map.sv */
// page decode for one special register address
`timescale 1ns/10ps
`default_nettype none
module dmd_sreg_map
  import dmd_pkg::*;
(
  input wire logic [7:0] addr_i,
  input wire logic [7:0] page_i,
  output logic own_o,
  output logic common_o,
  output logic [7:0] page_o
);
  always_comb begin
    own_o = (addr_i == A_STACK_POINTER) || (addr_i == A_PAGE_SELECT) ||
            (addr_i == A_STATUS_WORD);
    common_o = own_o || (addr_i == A_DPTR_LOW) || (addr_i == A_DPTR_HIGH) ||
               (addr_i == A_ACCUM) || (addr_i == A_B_REG);
    // common registers ignore the page so they look alike everywhere
    page_o = common_o ? COMMON_PAGE : page_i;
  end
endmodule
`default_nettype wire

/* File: design/dmd_decoder.sv */
// data memory, special register and expansion ram decoder
//
// Functional notes
// R01 - 256 byte internal ram at 0x00-0xFF
// R02 - lower 128 bytes: direct or indirect
// R03 - direct above 0x7F goes to special registers
// R04 - indirect above 0x7F reaches upper ram
// R05 - four banks, bank bits pick one
// R06 - indirect pointer from active index register zero/one
// R07 - bytes 0x20-0x2F as 128 bits
// R08 - bit or byte by operand type
// R09 - push writes stack_pointer+1, then increments
// R10 - stack_pointer resets to 0x07
// R11 - only low nibble 0/8 bit addressable
// R12 - 256 pages by register_page_select
// R13 - common registers same on every page
// R14 - software selects page before direct access
// R15 - software avoids unoccupied register addresses
// R16 - handlers save and restore page select
// R17 - 4096 byte expansion ram aliased to 0xFFFF
// R18 - code reads flash; moves may write flash
// R19 - 64 KB program space, no data fetch
// R20 - page select resets to zero
// R21 - stack_pointer eight bits, wraps mod 256
`timescale 1ns/10ps
`default_nettype none
module dmd_decoder
  import dmd_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  input wire logic CE_I,
  input wire logic CPU_REQ_I,
  input wire logic [2:0] CPU_KIND_I,
  input wire logic [15:0] CPU_ADDR_I,
  input wire logic CPU_WE_I,
  input wire logic [7:0] CPU_WDATA_I,
  output logic CPU_READY_O,
  output logic CPU_ACK_O,
  output logic [7:0] CPU_RDATA_O,
  output logic SREG_SEL_O,
  output logic SREG_WE_O,
  output logic [7:0] SREG_ADDR_O,
  output logic [7:0] SREG_PAGE_O,
  output logic [7:0] SREG_WDATA_O,
  input wire logic [7:0] SREG_RDATA_I,
  output logic FLASH_RD_O,
  output logic FLASH_WE_O,
  output logic [15:0] FLASH_ADDR_O,
  output logic [7:0] FLASH_WDATA_O,
  input wire logic [7:0] FLASH_RDATA_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] iram [IRAM_DEPTH];
  logic [7:0] expansion_ram [EXPANSION_RAM_DEPTH];
  dmd_state_t st_r, st_nxt;
  dmd_kind_t kind, k_r;
  logic [7:0] stack_pointer_r, program_status_word_r, register_page_select_r;
  logic [7:0] ea_r, wd_r, pointer, ea, eff_page, own_rd, own_wval;
  logic [7:0] cur_byte, sreg_mod, ap_off_r;
  logic [2:0] bp_r;
  logic [11:0] xa_r;
  logic [1:0] bank;
  logic redirect_r, we_r, ram_r, own_r, ext_r, common_r, redir_wr_r;
  logic take, to_ram, to_sreg, own, common, need_wb, ap_wr_r, ap_go;

  assign take = CE_I && CPU_REQ_I && (st_r == ST_IDLE);
  assign kind = dmd_kind_t'(CPU_KIND_I);
  assign bank = program_status_word_r[BANK_SELECT_LOW_POS +: 2]; // R05
  ////////////////////////////////////////////////////////////////////////////
  // request decode, from the address phase of the core
  always_comb begin
    // pointer comes from the active bank, index register 0 or 1
    pointer = iram[{3'h0, bank, 2'h0, CPU_ADDR_I[0]}]; // R06
    ea = CPU_ADDR_I[7:0];
    to_ram = 1'b0;
    to_sreg = 1'b0;
    case (kind)
      K_DIRECT: begin
        to_ram = (CPU_ADDR_I[7:0] <= DIRECT_RAM_TOP); // R02
        to_sreg = !to_ram; // R03
      end
      K_INDIRECT: begin
        ea = pointer;
        to_ram = 1'b1; // R04
      end
      K_BIT: begin
        // bit space: low half maps into 0x20-0x2F, high half onto
        // register addresses ending in 0 or 8 only
        if (CPU_ADDR_I[7]) begin
          ea = {CPU_ADDR_I[7:3], 3'h0}; // R11
          to_sreg = 1'b1;
        end else begin
          ea = {BIT_BYTE_BASE_HI, CPU_ADDR_I[6:3]}; // R07
          to_ram = 1'b1;
        end
      end
      K_PUSH: begin
        ea = stack_pointer_r + 8'h01; // R09 R21
        to_ram = 1'b1;
      end
      K_POP: begin
        ea = stack_pointer_r;
        to_ram = 1'b1;
      end
      default: begin
      end
    endcase
  end

  dmd_sreg_map u_map (
    .addr_i(ea),
    .page_i(register_page_select_r),
    .own_o(own),
    .common_o(common),
    .page_o(eff_page)
  );
  ////////////////////////////////////////////////////////////////////////////
  // execute-stage data paths
  always_comb begin
    cur_byte = iram[ea_r];
    case (ea_r)
      A_STACK_POINTER: own_rd = stack_pointer_r;
      A_PAGE_SELECT: own_rd = register_page_select_r;
      A_STATUS_WORD: own_rd = program_status_word_r;
      default: own_rd = 8'h00;
    endcase
    own_wval = wd_r;
    if (k_r == K_BIT) begin
      own_wval = own_rd;
      own_wval[bp_r] = wd_r[0]; // R08
    end
    sreg_mod = SREG_RDATA_I;
    sreg_mod[bp_r] = wd_r[0];
    need_wb = ext_r && we_r && (k_r == K_BIT);
  end
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: if (take) st_nxt = ST_EXEC;
      ST_EXEC: st_nxt = need_wb ? ST_WBAK : ST_IDLE;
      ST_WBAK: st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      st_r <= ST_IDLE;
      CPU_READY_O <= 1'b0;
    end else if (CE_I) begin
      st_r <= st_nxt;
      CPU_READY_O <= (st_nxt == ST_IDLE);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // latch the decoded request
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      k_r <= K_DIRECT;
      ea_r <= 8'h00;
      bp_r <= 3'h0;
      we_r <= 1'b0;
      wd_r <= 8'h00;
      xa_r <= 12'h000;
      ram_r <= 1'b0;
      own_r <= 1'b0;
      ext_r <= 1'b0;
      common_r <= 1'b0;
      redir_wr_r <= 1'b0;
    end else if (take) begin
      k_r <= kind;
      ea_r <= ea;
      bp_r <= CPU_ADDR_I[2:0];
      we_r <= CPU_WE_I;
      wd_r <= CPU_WDATA_I;
      // every 4 KB window aliases the same storage
      xa_r <= CPU_ADDR_I[EXPANSION_RAM_AW-1:0]; // R17
      ram_r <= to_ram;
      own_r <= to_sreg && own;
      ext_r <= to_sreg && !own;
      common_r <= common;
      redir_wr_r <= (kind == K_XMOVE) && CPU_WE_I && redirect_r; // R18
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // internal ram; writes only in execute so reads never see a half update
  always_ff @(posedge CLK_SYS_I) begin
    if (CE_I && (st_r == ST_EXEC) && ram_r && we_r) begin
      if (k_r == K_BIT)
        iram[ea_r][bp_r] <= wd_r[0]; // R07 R08
      else
        iram[ea_r] <= wd_r; // R01 R09
    end
  end
  // expansion ram; redirected writes leave it untouched
  always_ff @(posedge CLK_SYS_I) begin
    if (CE_I && (st_r == ST_EXEC) && (k_r == K_XMOVE) && we_r && !redir_wr_r)
      expansion_ram[xa_r] <= wd_r; // R17
  end
  ////////////////////////////////////////////////////////////////////////////
  // own special registers
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      stack_pointer_r <= STACK_POINTER_RST; // R10
    end else if (CE_I && (st_r == ST_EXEC)) begin
      if (k_r == K_PUSH)
        stack_pointer_r <= stack_pointer_r + 8'h01; // R09 R21
      else if (k_r == K_POP)
        stack_pointer_r <= stack_pointer_r - 8'h01; // R21
      else if (own_r && we_r && ea_r == A_STACK_POINTER)
        stack_pointer_r <= own_wval;
    end
  end
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      register_page_select_r <= PAGE_SELECT_RST; // R20
    end else if (CE_I && (st_r == ST_EXEC) && own_r && we_r &&
                 ea_r == A_PAGE_SELECT) begin
      register_page_select_r <= own_wval; // R12
    end
  end
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      program_status_word_r <= STATUS_WORD_RST;
    end else if (CE_I && (st_r == ST_EXEC) && own_r && we_r &&
                 ea_r == A_STATUS_WORD) begin
      program_status_word_r <= own_wval; // R05
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // peripheral register strobes; bit writes are read, then written back
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      SREG_SEL_O <= 1'b0;
      SREG_WE_O <= 1'b0;
      SREG_ADDR_O <= 8'h00;
      SREG_PAGE_O <= PAGE_SELECT_RST;
      SREG_WDATA_O <= 8'h00;
    end else if (CE_I) begin
      SREG_SEL_O <= 1'b0;
      SREG_WE_O <= 1'b0;
      if (take && to_sreg && !own) begin
        SREG_SEL_O <= 1'b1; // R03
        SREG_WE_O <= CPU_WE_I && (kind != K_BIT);
        SREG_ADDR_O <= ea;
        SREG_PAGE_O <= eff_page; // R12 R13
        SREG_WDATA_O <= CPU_WDATA_I;
      end else if (st_r == ST_EXEC && need_wb) begin
        SREG_SEL_O <= 1'b1;
        SREG_WE_O <= 1'b1; // R08
        SREG_WDATA_O <= sreg_mod;
      end
    end
  end
  // flash port: the only program space path, 16-bit address, 8-bit data
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      FLASH_RD_O <= 1'b0;
      FLASH_WE_O <= 1'b0;
      FLASH_ADDR_O <= 16'h0000;
      FLASH_WDATA_O <= 8'h00;
    end else if (CE_I) begin
      FLASH_RD_O <= take && (kind == K_CODE); // R18 R19
      FLASH_WE_O <= take && (kind == K_XMOVE) && CPU_WE_I && redirect_r;
      if (take) begin
        FLASH_ADDR_O <= CPU_ADDR_I; // R19
        FLASH_WDATA_O <= CPU_WDATA_I;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // answer to the core
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      CPU_ACK_O <= 1'b0;
      CPU_RDATA_O <= 8'h00;
    end else if (CE_I) begin
      CPU_ACK_O <= (st_r == ST_EXEC && !need_wb) || (st_r == ST_WBAK);
      if (st_r == ST_EXEC) begin
        case (k_r)
          K_BIT: CPU_RDATA_O <= {7'h00, (ram_r ? cur_byte[bp_r] :
                   own_r ? own_rd[bp_r] : SREG_RDATA_I[bp_r])}; // R08
          K_XMOVE: CPU_RDATA_O <= expansion_ram[xa_r];
          K_CODE: CPU_RDATA_O <= FLASH_RDATA_I;
          default: CPU_RDATA_O <= ram_r ? cur_byte :
                                 own_r ? own_rd : SREG_RDATA_I;
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait; hsize unused as only words are mapped
  assign ap_go = HSEL_I && HREADY_I && HTRANS_I[1];
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ap_wr_r <= 1'b0;
      ap_off_r <= 8'h00;
      HRDATA_O <= 32'h0000_0000;
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end else if (CE_I) begin
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
      if (HREADY_I) begin
        ap_wr_r <= ap_go && HWRITE_I;
        ap_off_r <= HADDR_I[7:0];
      end
      if (ap_go && !HWRITE_I) begin
        case (HADDR_I[7:0])
          OFF_CTRL: HRDATA_O <= {31'h0000_0000, redirect_r};
          OFF_STATUS: HRDATA_O <= {7'h00, (st_r != ST_IDLE),
            program_status_word_r, register_page_select_r,
            stack_pointer_r};
          default: HRDATA_O <= 32'h0000_0000;
        endcase
      end
    end
  end
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I)
      redirect_r <= 1'b0;
    else if (CE_I && ap_wr_r && ap_off_r == OFF_CTRL)
      redirect_r <= HWDATA_I[CTRL_REDIRECT_POS];
  end
  ////////////////////////////////////////////////////////////////////////////
  AST_DIRECT_HIGH_SREG: assert property ( // R03
    @(posedge CLK_SYS_I iff CE_I) disable iff (!RESETN_I)
    take && kind == K_DIRECT && CPU_ADDR_I[7] && !own |=>
    SREG_SEL_O && SREG_ADDR_O == $past(CPU_ADDR_I[7:0]))
    else $error("direct high access missed register space");
  AST_INDIRECT_RAM: assert property ( // R04
    @(posedge CLK_SYS_I iff CE_I) disable iff (!RESETN_I)
    take && kind == K_INDIRECT |=> !SREG_SEL_O ##1 !SREG_SEL_O)
    else $error("indirect access reached register space");
  AST_ACK_LATENCY: assert property ( // R02
    @(posedge CLK_SYS_I iff CE_I) disable iff (!RESETN_I)
    take |-> ##[2:3] CPU_ACK_O)
    else $error("access not answered in time");
  AST_PUSH_SP: assert property ( // R09
    @(posedge CLK_SYS_I iff CE_I) disable iff (!RESETN_I)
    take && kind == K_PUSH |=> ##1 stack_pointer_r == ea_r)
    else $error("push did not step stack pointer onto written byte");
  AST_PAGE_OUT: assert property ( // R12
    @(posedge CLK_SYS_I iff CE_I) disable iff (!RESETN_I)
    take && to_sreg && !own && !common |=>
    SREG_PAGE_O == register_page_select_r)
    else $error("register page not forwarded");
  AST_COMMON_PAGE: assert property ( // R13
    @(posedge CLK_SYS_I iff CE_I) disable iff (!RESETN_I)
    SREG_SEL_O && common_r |-> SREG_PAGE_O == COMMON_PAGE)
    else $error("common register decoded by page");
  AST_FLASH_REDIRECT: assert property ( // R18
    @(posedge CLK_SYS_I iff CE_I) disable iff (!RESETN_I)
    take && kind == K_XMOVE && CPU_WE_I |=> FLASH_WE_O == $past(redirect_r))
    else $error("move write redirect wrong");
  AST_CODE_FLASH: assert property ( // R18
    @(posedge CLK_SYS_I iff CE_I) disable iff (!RESETN_I)
    take && kind == K_CODE |=> FLASH_RD_O ##1 CPU_ACK_O)
    else $error("code read not sent to flash");
  AST_BIT_SREG_WB: assert property ( // R11
    @(posedge CLK_SYS_I iff CE_I) disable iff (!RESETN_I)
    SREG_SEL_O && k_r == K_BIT |-> SREG_ADDR_O[2:0] == 3'h0)
    else $error("bit access to non bit addressable register");
endmodule
`default_nettype wire

/* File: bench/dmd_far_model.sv */
// peripheral register and flash model on the decoder's far side
`timescale 1ns/10ps
`default_nettype none
module dmd_far_model
  import dmd_pkg::*;
(
  input wire logic clk_i,
  input wire logic sel_i,
  input wire logic we_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] page_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic frd_i,
  input wire logic fwe_i,
  input wire logic [15:0] faddr_i,
  input wire logic [7:0] fwdata_i,
  output logic [7:0] frdata_o,
  output logic [23:0] fwr_o
);
  logic [7:0] regs_r [256];
  logic [7:0] last_r;
  logic [7:0] flast_r;
  ////////////////////////////////////////////////////////////////////////
  // page folded into read data so a wrong page shows up as wrong data
  initial begin
    for (int i = 0; i < 256; i++) begin
      regs_r[i] = i[7:0];
    end
    last_r = 8'h00;
    flast_r = 8'h00;
    fwr_o = 24'h000000;
  end
  // released lines show the inverse of the last value, never a hold
  assign rdata_o = sel_i ? (regs_r[addr_i] ^ page_i) : ~last_r;
  assign frdata_o = frd_i ? (faddr_i[15:8] ^ faddr_i[7:0]) : ~flast_r;
  always @(posedge clk_i) begin
    if (sel_i) begin
      last_r <= rdata_o;
    end
    if (sel_i && we_i) begin
      regs_r[addr_i] <= wdata_i;
    end
    if (frd_i) begin
      flast_r <= frdata_o;
    end
    if (fwe_i) begin
      fwr_o <= {faddr_i, fwdata_i};
    end
  end
endmodule
`default_nettype wire

/* File: bench/dmd_decoder_tb.sv */
// self-checking bench for the data memory and special register decoder
`timescale 1ns/10ps
`default_nettype none
module dmd_decoder_tb;
  import dmd_pkg::*;
  typedef struct packed {
    logic [2:0] kind;
    logic [15:0] addr;
    logic we;
    logic [7:0] wd;
    logic [7:0] exp;
  } dmd_row_t;
  logic clk, rst_n, req, we, ready, ack, ssel, swe, frd, fwe;
  logic [2:0] kind, hsize;
  logic [15:0] addr, faddr;
  logic [7:0] wd, rdata, saddr, spage, swd, srd, fwd, frdd, q;
  logic hsel, hwrite, hready, hresp;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, hq;
  logic [23:0] fwr;
  int failures, cmp_count;
  dmd_row_t rows [29] = '{
    '{K_DIRECT, 16'h0005, 1'b1, 8'h11, 8'h00},
    '{K_DIRECT, 16'h0005, 1'b0, 8'h00, 8'h11},
    '{K_DIRECT, 16'h0000, 1'b1, 8'hC0, 8'h00},
    '{K_INDIRECT, 16'h0000, 1'b1, 8'h5A, 8'h00},
    '{K_INDIRECT, 16'h0000, 1'b0, 8'h00, 8'h5A},
    '{K_DIRECT, 16'h00C0, 1'b0, 8'h00, 8'hC0},
    '{K_DIRECT, 16'h0040, 1'b1, 8'h33, 8'h00},
    '{K_DIRECT, 16'h0001, 1'b1, 8'h40, 8'h00},
    '{K_INDIRECT, 16'h0001, 1'b0, 8'h00, 8'h33},
    '{K_DIRECT, 16'h00D0, 1'b1, 8'h08, 8'h00},
    '{K_DIRECT, 16'h0008, 1'b1, 8'h40, 8'h00},
    '{K_INDIRECT, 16'h0000, 1'b0, 8'h00, 8'h33},
    '{K_DIRECT, 16'h00D0, 1'b1, 8'h00, 8'h00},
    '{K_DIRECT, 16'h0022, 1'b1, 8'h00, 8'h00},
    '{K_BIT, 16'h0013, 1'b1, 8'h01, 8'h00},
    '{K_DIRECT, 16'h0022, 1'b0, 8'h00, 8'h08},
    '{K_BIT, 16'h0013, 1'b0, 8'h00, 8'h01},
    '{K_BIT, 16'h0012, 1'b0, 8'h00, 8'h00},
    '{K_DIRECT, 16'h00A7, 1'b1, 8'h0F, 8'h00},
    '{K_DIRECT, 16'h00C0, 1'b0, 8'h00, 8'hCF},
    '{K_DIRECT, 16'h00E0, 1'b0, 8'h00, 8'hE0},
    '{K_DIRECT, 16'h00A7, 1'b0, 8'h00, 8'h0F},
    '{K_DIRECT, 16'h00A7, 1'b1, 8'h00, 8'h00},
    '{K_BIT, 16'h0099, 1'b1, 8'h01, 8'h00},
    '{K_DIRECT, 16'h0098, 1'b0, 8'h00, 8'h9A},
    '{K_XMOVE, 16'h0123, 1'b1, 8'h77, 8'h00},
    '{K_XMOVE, 16'h1123, 1'b0, 8'h00, 8'h77},
    '{K_XMOVE, 16'hF123, 1'b0, 8'h00, 8'h77},
    '{K_CODE, 16'h4321, 1'b0, 8'h00, 8'h62}
  };
  ////////////////////////////////////////////////////////////////////////
  dmd_decoder dut (
    .CLK_SYS_I(clk), .RESETN_I(rst_n), .CE_I(1'b1), .CPU_REQ_I(req),
    .CPU_KIND_I(kind), .CPU_ADDR_I(addr), .CPU_WE_I(we),
    .CPU_WDATA_I(wd), .CPU_READY_O(ready), .CPU_ACK_O(ack),
    .CPU_RDATA_O(rdata), .SREG_SEL_O(ssel), .SREG_WE_O(swe),
    .SREG_ADDR_O(saddr), .SREG_PAGE_O(spage), .SREG_WDATA_O(swd),
    .SREG_RDATA_I(srd), .FLASH_RD_O(frd), .FLASH_WE_O(fwe),
    .FLASH_ADDR_O(faddr), .FLASH_WDATA_O(fwd), .FLASH_RDATA_I(frdd),
    .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
    .HRESP_O(hresp)
  );
  dmd_far_model far (
    .clk_i(clk), .sel_i(ssel), .we_i(swe), .addr_i(saddr),
    .page_i(spage), .wdata_i(swd), .rdata_o(srd), .frd_i(frd),
    .fwe_i(fwe), .faddr_i(faddr), .fwdata_i(fwd), .frdata_o(frdd),
    .fwr_o(fwr)
  );
  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // request dropped at the take edge, else a second take at ack
  task automatic acc(input logic [2:0] k, input logic [15:0] a,
                     input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    req <= 1'b1;
    kind <= k;
    addr <= a;
    we <= w;
    wd <= d;
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (ack !== 1'b1 && n < 8);
    q = rdata;
    chk({31'h0, ack}, 32'h1);
  endtask
  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    hq = hrdata;
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    wrap_up;
  end
  initial begin
    {clk, req, we, hsel, hwrite, kind, addr, wd, htrans, haddr} = '0;
    {rst_n, hwdata, failures, cmp_count} = '0;
    hsize = 3'h2;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      acc(rows[i].kind, rows[i].addr, rows[i].we, rows[i].wd);
      if (!rows[i].we) chk(q, rows[i].exp);
    end
    // handler style: save the page, switch, then restore it
    acc(K_DIRECT, 16'h00A7, 1'b1, 8'h0F);
    acc(K_DIRECT, 16'h00A7, 1'b0, 8'h00);
    hq = {24'h0, q};
    acc(K_DIRECT, 16'h00A7, 1'b1, 8'h03);
    acc(K_DIRECT, 16'h00C0, 1'b0, 8'h00);
    chk(q, 8'hC3);
    acc(K_DIRECT, 16'h00A7, 1'b1, hq[7:0]);
    acc(K_DIRECT, 16'h00A7, 1'b0, 8'h00);
    chk(q, 8'h0F);
    // redirected external writes land on the flash port
    ahb(1'b1, OFF_CTRL, 32'h1);
    ahb(1'b0, OFF_CTRL, 32'h0);
    chk(hq, 32'h1);
    ahb(1'b0, 32'h8, 32'h0);
    chk({hq[31:1], hresp}, 32'h0);
    acc(K_XMOVE, 16'h0200, 1'b1, 8'h44);
    chk(fwr, 24'h020044);
    ahb(1'b1, OFF_CTRL, 32'h0);
    // second reset in mid-run
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    chk({ready, hready}, 32'h1);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    ahb(1'b0, OFF_STATUS, 32'h0);
    chk(hq, 32'h7);
    acc(K_PUSH, 16'h0000, 1'b1, 8'hA5);
    acc(K_DIRECT, 16'h0008, 1'b0, 8'h00);
    chk(q, 8'hA5);
    ahb(1'b0, OFF_STATUS, 32'h0);
    chk(hq, 32'h8);
    acc(K_POP, 16'h0000, 1'b0, 8'h00);
    chk(q, 8'hA5);
    // stack pointer wraps from the top of internal ram
    acc(K_DIRECT, 16'h0081, 1'b1, 8'hFF);
    acc(K_PUSH, 16'h0000, 1'b1, 8'h3C);
    acc(K_DIRECT, 16'h0000, 1'b0, 8'h00);
    chk(q, 8'h3C);
    ahb(1'b0, OFF_STATUS, 32'h0);
    chk(hq, 32'h0);
    wrap_up;
  end
endmodule
`default_nettype wire
